// ===== pkg/fcr_map.svh
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define FCR_OP_WRITE_REGS 8'h01
`define FCR_OP_READ_STAT2 8'h07
`define FCR_OP_RDCR      8'h35
`define FCR_OP_SRST      8'hF0
`define FCR_OP_ESUSP     8'h75
`define FCR_OP_ERES      8'h7A
`define FCR_OP_PSUSP     8'h85
`define FCR_OP_PRES      8'h8A
`define FCR_OP_READ3     8'h03
`define FCR_OP_READ4     8'h13
`define FCR_OP_FAST3     8'h0B
`define FCR_OP_FAST4     8'h0C
`define FCR_OP_DOUT3     8'h3B
`define FCR_OP_DOUT4     8'h3C
`define FCR_OP_QOUT3     8'h6B
`define FCR_OP_QOUT4     8'h6C
`define FCR_OP_DIO3      8'hBB
`define FCR_OP_DIO4      8'hBC
`define FCR_OP_QIO3      8'hEB
`define FCR_OP_QIO4      8'hEC
`define FCR_OP_DDRF3     8'h0D
`define FCR_OP_DDRF4     8'h0E
`define FCR_OP_DDRD3     8'hBD
`define FCR_OP_DDRD4     8'hBE
`define FCR_OP_DDRQ3     8'hED
`define FCR_OP_DDRQ4     8'hEE
`define FCR_OP_QPP       8'h32

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FCR_CR_LAT       7:6
`define FCR_CR_ORIGIN    5
`define FCR_CR_VOLAT     3
`define FCR_CR_PARM      2
`define FCR_CR_QUAD      1
`define FCR_CR_FREEZE    0
`define FCR_STAT1_BP     4:2
`define FCR_STAT1_PERR   6
`define FCR_STAT2_ERASE  1
`define FCR_STAT2_PROG   0
`define FCR_BP_VOL_RST   3'h7
`define FCR_BP_RST       3'h0
`define FCR_LAT_RST      2'h0
`define FCR_LAT_SLOW     2'h3
`define FCR_BITS_BYTE    3'h7
`define FCR_WR_FULL      2'h2

// ----------------------------------------------------------------
// Latency tables, one nibble per code, code 3 in the top nibble
// ----------------------------------------------------------------
`define FCR_DUMMY_FAST   16'h0888
`define FCR_DUMMY_DIO    16'h0210
`define FCR_DUMMY_QIO    16'h1544
`define FCR_DUMMY_DDRF   16'h1542
`define FCR_DUMMY_DDRD   16'h2654
`define FCR_DUMMY_DDRQ   16'h3876
`define FCR_MODE_NONE    4'h0
`define FCR_MODE_DIO     4'h4
`define FCR_MODE_QIO     4'h2
`define FCR_MODE_DDRF    4'h4
`define FCR_MODE_DDRD    4'h2
`define FCR_MODE_DDRQ    4'h1

`endif

// ===== pkg/fcr_pkg.sv
package fcr_pkg;

  typedef enum logic [1:0]
  {
    fcr_st_cmd  = 2'b00,
    fcr_st_wr   = 2'b01,
    fcr_st_rd   = 2'b10,
    fcr_st_skip = 2'b11
  } fcr_state_t;

endpackage : fcr_pkg

// ===== src/fcr_core.sv
// How it works
// - Latency code picks dummy cycles; mode cycles are fixed per command.
// - Single-rate table for the enhanced settings.
// - Double-rate table for the enhanced settings.
// - Origin bit: protect from top or bottom.
// - OTP bits never return to zero; error unless freeze is set.
// - Volatile protect bits become 111 on reset.
// - Parameter block top when location bit set.
// - Uniform sectors make location bit meaningless.
// - Origin and location bits are independent.
// - Quad bit turns protect/hold pins into data.
// - Freeze blocks protect, origin, location; volatile bit stays writable.
// - Unfrozen, other configuration bits stay writable.
// - Freeze clears only on power or hardware reset.
// - Freeze may be set in same write.
// - Second status read; upper bits read zero.
// - Erase suspend flag follows suspend/resume commands.
// - Program suspend flag follows suspend/resume commands.
`timescale 1ns/100ps
`include "fcr_map.svh"

module fcr_core
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       hw_reset_n,
  input  wire logic       uniform_sectors,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sck,
  input  wire logic       spi_si,
  input  wire logic       wp_n,
  input  wire logic       hold_n,
  output logic            spi_so,
  output logic            spi_so_oe_n,
  output logic [1:0]      latency_code,
  output logic [3:0]      read_mode_cycles,
  output logic [3:0]      read_dummy_cycles,
  output logic            read_unsupported,
  output logic            quad_cmd_error,
  output logic [2:0]      block_protect_bits,
  output logic            protect_from_bottom,
  output logic            bp_volatile,
  output logic            param_block_top,
  output logic            param_block_used,
  output logic            quad_mode,
  output logic            wp_active,
  output logic            hold_active,
  output logic            freeze_locked,
  output logic            program_error,
  output logic            erase_suspended_flag,
  output logic            program_suspended_flag
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_s_ff, si_s_ff, hw_s_ff, uni_s_ff, wp_s_ff, hold_s_ff;
  logic [2:0] sck_s_ff;
  logic       cs_d_ff;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cs_s_ff   <= 2'h3;
      cs_d_ff   <= 1'b1;
      sck_s_ff  <= 3'h0;
      si_s_ff   <= 2'h0;
      hw_s_ff   <= 2'h3;
      uni_s_ff  <= 2'h0;
      wp_s_ff   <= 2'h3;
      hold_s_ff <= 2'h3;
    end
    else if (clk_en)
    begin
      cs_s_ff   <= {cs_s_ff[0], spi_cs_n};
      cs_d_ff   <= cs_s_ff[1];
      sck_s_ff  <= {sck_s_ff[1:0], spi_sck};
      si_s_ff   <= {si_s_ff[0], spi_si};
      hw_s_ff   <= {hw_s_ff[0], hw_reset_n};
      uni_s_ff  <= {uni_s_ff[0], uniform_sectors};
      wp_s_ff   <= {wp_s_ff[0], wp_n};
      hold_s_ff <= {hold_s_ff[0], hold_n};
    end
  end

  logic hw_ok, active, sck_rise, sck_fall, cs_rise;
  assign hw_ok    = hw_s_ff[1];
  assign active   = ~cs_s_ff[1] & hw_ok;
  assign sck_rise = sck_s_ff[1] & ~sck_s_ff[2];
  assign sck_fall = ~sck_s_ff[1] & sck_s_ff[2];
  assign cs_rise  = cs_s_ff[1] & ~cs_d_ff;

  // ----------------------------------------------------------------
  // Serial engine, mode 0: sample on rise, shift out on fall
  // ----------------------------------------------------------------
  fcr_pkg::fcr_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] rx_ff;
  logic [7:0] tx_ff, wr_sr_ff, wr_cr_ff, sel_reg_ff;
  logic [1:0] wr_cnt_ff;
  logic [7:0] rx_byte, cr_word, sr2_word;
  logic       byte_done, in_cmd, wr_commit, srst_evt;

  assign rx_byte   = {rx_ff, si_s_ff[1]};
  assign byte_done = active & sck_rise & (bit_cnt_ff == `FCR_BITS_BYTE);
  assign in_cmd    = byte_done & (state_ff == fcr_pkg::fcr_st_cmd);
  assign srst_evt  = in_cmd & (rx_byte == `FCR_OP_SRST);
  assign wr_commit = cs_rise & hw_ok & (state_ff == fcr_pkg::fcr_st_wr);

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff   <= fcr_pkg::fcr_st_cmd;
      bit_cnt_ff <= 3'h0;
      rx_ff      <= 7'h00;
      wr_cnt_ff  <= 2'h0;
      wr_sr_ff   <= 8'h00;
      wr_cr_ff   <= 8'h00;
      sel_reg_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      if (!active)
      begin
        state_ff   <= fcr_pkg::fcr_st_cmd;
        bit_cnt_ff <= 3'h0;
        wr_cnt_ff  <= 2'h0;
      end
      else if (sck_rise)
      begin
        rx_ff      <= rx_byte[6:0];
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (byte_done)
        begin
          unique case (state_ff)
            fcr_pkg::fcr_st_cmd:
            begin
              sel_reg_ff <= rx_byte;
              if (rx_byte == `FCR_OP_WRITE_REGS)
                state_ff <= fcr_pkg::fcr_st_wr;
              else if (rx_byte == `FCR_OP_READ_STAT2 || rx_byte == `FCR_OP_RDCR)
                state_ff <= fcr_pkg::fcr_st_rd;
              else
                state_ff <= fcr_pkg::fcr_st_skip;
            end
            fcr_pkg::fcr_st_wr:
            begin
              if (wr_cnt_ff == 2'h0)
                wr_sr_ff <= rx_byte;
              else
                wr_cr_ff <= rx_byte;
              if (wr_cnt_ff != `FCR_WR_FULL)
                wr_cnt_ff <= wr_cnt_ff + 2'h1;
            end
            fcr_pkg::fcr_st_rd, fcr_pkg::fcr_st_skip:
              state_ff <= state_ff;
          endcase
        end
      end
    end
  end

  // Register image is re-sent every byte, so reads may run continuously
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_ff       <= 8'h00;
      spi_so      <= 1'b0;
      spi_so_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      spi_so_oe_n <= ~(active & (state_ff == fcr_pkg::fcr_st_rd));
      if (in_cmd && rx_byte == `FCR_OP_READ_STAT2)
        tx_ff <= sr2_word;
      else if (in_cmd && rx_byte == `FCR_OP_RDCR)
        tx_ff <= cr_word;
      else if (byte_done && state_ff == fcr_pkg::fcr_st_rd)
        tx_ff <= (sel_reg_ff == `FCR_OP_READ_STAT2) ? sr2_word : cr_word;
      else if (active && sck_fall && state_ff == fcr_pkg::fcr_st_rd)
      begin
        spi_so <= tx_ff[7];
        tx_ff  <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and protection bits
  // ----------------------------------------------------------------
  logic [1:0] lat_code_ff;
  logic [2:0] bp_ff;
  logic       origin_ff, volat_ff, parm_ff, quad_ff, freeze_ff, perr_ff;
  logic       cr_written, otp_clear_try, any_reset;

  assign cr_word    = {lat_code_ff, origin_ff, 1'b0, volat_ff, parm_ff, quad_ff, freeze_ff};
  assign cr_written = wr_commit & (wr_cnt_ff == `FCR_WR_FULL);
  assign any_reset  = ~hw_ok | srst_evt;
  // Attempted clear of a programmed one-time bit
  assign otp_clear_try = cr_written & ~freeze_ff &
                         ((origin_ff & ~wr_cr_ff[`FCR_CR_ORIGIN]) |
                          (volat_ff & ~wr_cr_ff[`FCR_CR_VOLAT]) |
                          (parm_ff & ~wr_cr_ff[`FCR_CR_PARM]));

  // Nonvolatile bits survive hardware and software reset; only sys_rst
  // stands for a factory-fresh part.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lat_code_ff <= `FCR_LAT_RST;
      quad_ff   <= 1'b0;
      origin_ff <= 1'b0;
      volat_ff  <= 1'b0;
      parm_ff   <= 1'b0;
    end
    else if (clk_en && cr_written)
    begin
      lat_code_ff <= wr_cr_ff[`FCR_CR_LAT];
      quad_ff <= wr_cr_ff[`FCR_CR_QUAD];
      volat_ff <= volat_ff | wr_cr_ff[`FCR_CR_VOLAT];
      if (!freeze_ff)
      begin
        origin_ff <= origin_ff | wr_cr_ff[`FCR_CR_ORIGIN];
        parm_ff   <= parm_ff | wr_cr_ff[`FCR_CR_PARM];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      freeze_ff <= 1'b0;
    else if (clk_en)
    begin
      if (!hw_ok)
        freeze_ff <= 1'b0;
      else if (cr_written && wr_cr_ff[`FCR_CR_FREEZE])
        freeze_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      bp_ff <= `FCR_BP_RST;
    else if (clk_en)
    begin
      if (any_reset && volat_ff)
        bp_ff <= `FCR_BP_VOL_RST;
      // An opcode-only write carries no status byte; keep the old one out
      else if (wr_commit && wr_cnt_ff != 2'h0 && !freeze_ff)
        bp_ff <= wr_sr_ff[`FCR_STAT1_BP];
    end
  end

  // Error set wins over the reset clear
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      perr_ff <= 1'b0;
    else if (clk_en)
    begin
      if (otp_clear_try)
        perr_ff <= 1'b1;
      else if (any_reset)
        perr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Suspend flags, read-only to the host
  // ----------------------------------------------------------------
  logic erase_sus_ff, prog_sus_ff;
  assign sr2_word = {6'h00, erase_sus_ff, prog_sus_ff};

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      erase_sus_ff <= 1'b0;
      prog_sus_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (any_reset)
      begin
        erase_sus_ff <= 1'b0;
        prog_sus_ff  <= 1'b0;
      end
      else if (in_cmd)
      begin
        if (rx_byte == `FCR_OP_ESUSP)
          erase_sus_ff <= 1'b1;
        else if (rx_byte == `FCR_OP_ERES)
          erase_sus_ff <= 1'b0;
        if (rx_byte == `FCR_OP_PSUSP)
          prog_sus_ff <= 1'b1;
        else if (rx_byte == `FCR_OP_PRES)
          prog_sus_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read latency for the last read command seen
  // ----------------------------------------------------------------
  logic       lat_read, lat_ok, lat_quad;
  logic [3:0] lat_mode, lat_dummy;

  fcr_latency u_latency
  (
    .opcode       (rx_byte),
    .lat_code     (lat_code_ff),
    .is_read      (lat_read),
    .supported    (lat_ok),
    .needs_quad   (lat_quad),
    .mode_cycles  (lat_mode),
    .dummy_cycles (lat_dummy)
  );

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      read_mode_cycles  <= 4'h0;
      read_dummy_cycles <= 4'h0;
      read_unsupported  <= 1'b0;
      quad_cmd_error    <= 1'b0;
    end
    else if (clk_en && in_cmd)
    begin
      // Sampled per command: a later code change needs a new command
      if (lat_read)
      begin
        read_mode_cycles  <= lat_mode;
        read_dummy_cycles <= lat_dummy;
        read_unsupported  <= ~lat_ok;
      end
      quad_cmd_error <= (lat_quad | (rx_byte == `FCR_OP_QPP)) & ~quad_ff;
    end
  end

  // ----------------------------------------------------------------
  // Registered views of the configuration
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      latency_code           <= `FCR_LAT_RST;
      block_protect_bits     <= `FCR_BP_RST;
      protect_from_bottom    <= 1'b0;
      bp_volatile            <= 1'b0;
      param_block_top        <= 1'b0;
      param_block_used       <= 1'b0;
      quad_mode              <= 1'b0;
      wp_active              <= 1'b0;
      hold_active            <= 1'b0;
      freeze_locked          <= 1'b0;
      program_error          <= 1'b0;
      erase_suspended_flag   <= 1'b0;
      program_suspended_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      latency_code           <= lat_code_ff;
      block_protect_bits     <= bp_ff;
      protect_from_bottom    <= origin_ff;
      bp_volatile            <= volat_ff;
      param_block_used       <= ~uni_s_ff[1];
      param_block_top        <= parm_ff & ~uni_s_ff[1];
      quad_mode              <= quad_ff;
      wp_active              <= ~quad_ff & ~wp_s_ff[1];
      hold_active            <= ~quad_ff & ~hold_s_ff[1];
      freeze_locked          <= freeze_ff;
      program_error          <= perr_ff;
      erase_suspended_flag   <= erase_sus_ff;
      program_suspended_flag <= prog_sus_ff;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_frozen_write;
    clk_en && wr_commit && freeze_ff && hw_ok;
  endsequence

  a_bp_forced_set: assert property (clk_en && any_reset && volat_ff |=>
      bp_ff == `FCR_BP_VOL_RST)
    else $error("volatile protect bits not forced to 111");
  a_freeze_blocks_wr: assert property (s_frozen_write |=>
      $stable(bp_ff) && $stable(origin_ff) && $stable(parm_ff))
    else $error("frozen field changed by write");
  a_freeze_soft_keep: assert property (clk_en && srst_evt && freeze_ff && hw_ok |=>
      freeze_ff)
    else $error("freeze lost on software reset");
  a_otp_stays_set: assert property (origin_ff && parm_ff |=> origin_ff && parm_ff)
    else $error("one-time bit returned to zero");
  a_otp_error_flag: assert property (clk_en && otp_clear_try |=> perr_ff ##2 program_error)
    else $error("program error not raised");
  a_sr2_upper_zero: assert property (clk_en && in_cmd && rx_byte == `FCR_OP_READ_STAT2
      |=> tx_ff[7:2] == 6'h00)
    else $error("status two reserved bits not zero");
  a_es_suspend_set: assert property (clk_en && in_cmd && hw_ok && rx_byte == `FCR_OP_ESUSP
      |=> erase_sus_ff)
    else $error("erase suspend flag not set");
  a_ps_resume_clr: assert property (clk_en && in_cmd && rx_byte == `FCR_OP_PRES
      |=> !prog_sus_ff)
    else $error("program suspend flag not cleared");
  a_fast_slow_lat: assert property (clk_en && in_cmd && rx_byte == `FCR_OP_FAST3
      && lat_code_ff == `FCR_LAT_SLOW
      |=> read_dummy_cycles == 4'h0 && read_mode_cycles == 4'h0)
    else $error("fast read latency wrong at slow code");
  a_quad_pins_off: assert property (clk_en && quad_ff |=> !wp_active && !hold_active)
    else $error("protect or hold active in quad mode");

endmodule : fcr_core

// ===== src/fcr_latency.sv
`timescale 1ns/100ps
`include "fcr_map.svh"

module fcr_latency
(
  input  wire logic [7:0] opcode,
  input  wire logic [1:0] lat_code,
  output logic            is_read,
  output logic            supported,
  output logic            needs_quad,
  output logic [3:0]      mode_cycles,
  output logic [3:0]      dummy_cycles
);

  function automatic logic [3:0] fcr_nib(input logic [15:0] tbl, input logic [1:0] sel);
    fcr_nib = tbl[{sel, 2'b00} +: 4];
  endfunction : fcr_nib

  always_comb
  begin
    is_read      = 1'b1;
    supported    = 1'b1;
    needs_quad   = 1'b0;
    mode_cycles  = `FCR_MODE_NONE;
    dummy_cycles = 4'h0;
    case (opcode)
      `FCR_OP_READ3, `FCR_OP_READ4:
        supported = (lat_code == `FCR_LAT_SLOW);
      `FCR_OP_FAST3, `FCR_OP_FAST4, `FCR_OP_DOUT3, `FCR_OP_DOUT4:
        dummy_cycles = fcr_nib(`FCR_DUMMY_FAST, lat_code);
      `FCR_OP_QOUT3, `FCR_OP_QOUT4:
      begin
        dummy_cycles = fcr_nib(`FCR_DUMMY_FAST, lat_code);
        needs_quad   = 1'b1;
      end
      `FCR_OP_DIO3, `FCR_OP_DIO4:
      begin
        mode_cycles  = `FCR_MODE_DIO;
        dummy_cycles = fcr_nib(`FCR_DUMMY_DIO, lat_code);
      end
      `FCR_OP_QIO3, `FCR_OP_QIO4:
      begin
        mode_cycles  = `FCR_MODE_QIO;
        dummy_cycles = fcr_nib(`FCR_DUMMY_QIO, lat_code);
        needs_quad   = 1'b1;
      end
      `FCR_OP_DDRF3, `FCR_OP_DDRF4:
      begin
        mode_cycles  = `FCR_MODE_DDRF;
        dummy_cycles = fcr_nib(`FCR_DUMMY_DDRF, lat_code);
      end
      `FCR_OP_DDRD3, `FCR_OP_DDRD4:
      begin
        mode_cycles  = `FCR_MODE_DDRD;
        dummy_cycles = fcr_nib(`FCR_DUMMY_DDRD, lat_code);
      end
      `FCR_OP_DDRQ3, `FCR_OP_DDRQ4:
      begin
        mode_cycles  = `FCR_MODE_DDRQ;
        dummy_cycles = fcr_nib(`FCR_DUMMY_DDRQ, lat_code);
        needs_quad   = 1'b1;
      end
      default:
      begin
        is_read   = 1'b0;
        supported = 1'b0;
      end
    endcase
  end

endmodule : fcr_latency

// ===== test/fcr_host.sv
`timescale 1ns/100ps

module fcr_host
(
  output logic       spi_cs_n,
  output logic       spi_sck,
  output logic       spi_si,
  input  wire logic  spi_so
);
  logic [7:0] rx_byte;

  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_si   = 1'b1;
    rx_byte  = 8'h00;
  end

  // Mode 0, MSB first; sck idles low between frames
  task automatic shift(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--)
    begin
      spi_si = tx[i];
      #200 spi_sck = 1'b1;
      // Late sample: output moves a few ref_clk after each fall
      #140 rx_byte[i] = spi_so;
      #60 spi_sck = 1'b0;
    end
  endtask : shift

  task automatic frame(input logic [23:0] data, input int n);
    // Callers start on a falling ref_clk edge; every pin change keeps that grid
    spi_cs_n = 1'b0;
    #400;
    for (int k = n - 1; k >= 0; k--)
      shift(data[8 * k +: 8]);
    #200 spi_cs_n = 1'b1;
    // Released line: no pull, so show the inverse level
    spi_si = ~spi_si;
    #1000;
  endtask : frame
endmodule : fcr_host

// ===== test/flash_config_status_regs_tb.sv
`timescale 1ns/100ps

module flash_config_status_regs_tb;
  typedef struct packed
  {
    logic [1:0] code;
    logic [7:0] op;
    logic [3:0] md;
    logic [3:0] dm;
    logic       un;
  } fcr_row_t;

  logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, hw_reset_n = 1'b1;
  logic uniform_sectors = 1'b0, wp_n = 1'b0, hold_n = 1'b0;
  wire logic spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe_n, read_unsupported, quad_mode;
  wire logic protect_from_bottom, bp_volatile, param_block_top, param_block_used, wp_active;
  wire logic hold_active, freeze_locked, program_error, erase_suspended_flag;
  wire logic program_suspended_flag, quad_cmd_error;
  wire logic [1:0] latency_code;
  wire logic [3:0] read_mode_cycles, read_dummy_cycles;
  wire logic [2:0] block_protect_bits;
  int errors = 0;
  int n_compared = 0;
  logic [7:0] sus_op [4] = '{8'h75, 8'h85, 8'h7A, 8'h8A};
  logic [7:0] sus_exp [4] = '{8'h02, 8'h03, 8'h01, 8'h00};

  // ----------------------------------------------------------------
  // Latency rows: code, opcode, mode, dummy, unsupported
  // ----------------------------------------------------------------
  fcr_row_t rows [20] = '{
    '{2'h3, 8'h03, 4'h0, 4'h0, 1'b0}, '{2'h1, 8'h13, 4'h0, 4'h0, 1'b1},
    '{2'h3, 8'h0B, 4'h0, 4'h0, 1'b0}, '{2'h0, 8'h0C, 4'h0, 4'h8, 1'b0},
    '{2'h2, 8'h3B, 4'h0, 4'h8, 1'b0}, '{2'h1, 8'h6C, 4'h0, 4'h8, 1'b0},
    '{2'h3, 8'hBB, 4'h4, 4'h0, 1'b0}, '{2'h1, 8'hBC, 4'h4, 4'h1, 1'b0},
    '{2'h2, 8'hBB, 4'h4, 4'h2, 1'b0}, '{2'h3, 8'hEB, 4'h2, 4'h1, 1'b0},
    '{2'h0, 8'hEC, 4'h2, 4'h4, 1'b0}, '{2'h2, 8'hEB, 4'h2, 4'h5, 1'b0},
    '{2'h3, 8'h0D, 4'h4, 4'h1, 1'b0}, '{2'h1, 8'h0E, 4'h4, 4'h4, 1'b0},
    '{2'h2, 8'h0D, 4'h4, 4'h5, 1'b0}, '{2'h3, 8'hBD, 4'h2, 4'h2, 1'b0},
    '{2'h0, 8'hBE, 4'h2, 4'h4, 1'b0}, '{2'h3, 8'hED, 4'h1, 4'h3, 1'b0},
    '{2'h1, 8'hEE, 4'h1, 4'h7, 1'b0}, '{2'h2, 8'hED, 4'h1, 4'h8, 1'b0}};

  fcr_core uut (.ref_clk, .sys_rst, .clk_en, .hw_reset_n, .uniform_sectors, .spi_cs_n,
    .spi_sck, .spi_si, .wp_n, .hold_n, .spi_so, .spi_so_oe_n, .latency_code,
    .read_mode_cycles, .read_dummy_cycles, .read_unsupported, .quad_cmd_error,
    .block_protect_bits, .protect_from_bottom, .bp_volatile, .param_block_top,
    .param_block_used, .quad_mode, .wp_active, .hold_active, .freeze_locked,
    .program_error, .erase_suspended_flag, .program_suspended_flag);

  fcr_host host (.spi_cs_n, .spi_sck, .spi_si, .spi_so);

  always #25 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic rd(input logic [7:0] op, input logic [7:0] exp, input string nm);
    host.frame({8'h00, op, 8'h00}, 2);
    chk(nm, exp, host.rx_byte);
  endtask : rd

  initial
  begin
    #2000000;
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("oe_n", 8'h01, {7'h00, spi_so_oe_n});
    chk("freeze", 8'h00, {7'h00, freeze_locked});
    chk("wp quad off", 8'h03, {6'h00, wp_active, hold_active});
    $display("test reset done");
    foreach (rows[i])
    begin
      host.frame({8'h01, 8'h00, rows[i].code, 6'h02}, 3);
      host.frame({16'h0000, rows[i].op}, 1);
      chk("code", {6'h00, rows[i].code}, {6'h00, latency_code});
      chk("unsupported", {7'h00, rows[i].un}, {7'h00, read_unsupported});
      chk("quad err", 8'h00, {7'h00, quad_cmd_error});
      if (!rows[i].un)
        chk("mode dummy", {rows[i].md, rows[i].dm},
            {read_mode_cycles, read_dummy_cycles});
    end
    chk("wp quad on", 8'h04, {5'h00, quad_mode, wp_active, hold_active});
    host.frame({8'h01, 8'h00, 8'h00}, 3);
    host.frame({16'h0000, 8'h6B}, 1);
    chk("quad err", 8'h01, {7'h00, quad_cmd_error});
    $display("test latency done");
    for (int i = 0; i < 4; i++)
    begin
      host.frame({16'h0000, sus_op[i]}, 1);
      rd(8'h07, sus_exp[i], "status two");
      chk("flags", sus_exp[i], {6'h00, erase_suspended_flag, program_suspended_flag});
    end
    $display("test suspend done");
    host.frame({8'h01, 8'h00, 8'h22}, 3);
    chk("origin set", 8'h02, {6'h00, protect_from_bottom, param_block_top});
    host.frame({8'h01, 8'h00, 8'h06}, 3);
    chk("origin kept", 8'h07,
        {5'h00, protect_from_bottom, param_block_top, program_error});
    uniform_sectors = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("param used", 8'h00, {7'h00, param_block_used});
    host.frame({8'h01, 8'h08, 8'h2E}, 3);
    chk("bp vol", 8'h0A, {4'h0, bp_volatile, block_protect_bits});
    rd(8'h35, 8'h2E, "config");
    host.frame({16'h0000, 8'hF0}, 1);
    chk("soft rst", 8'h07, {4'h0, program_error, block_protect_bits});
    host.frame({16'h0000, 8'h01}, 1);
    chk("bare write", 8'h07, {5'h00, block_protect_bits});
    $display("test otp done");
    host.frame({8'h01, 8'h04, 8'h2F}, 3);
    chk("freeze set", 8'h09, {4'h0, freeze_locked, block_protect_bits});
    host.frame({8'h01, 8'h00, 8'h0F}, 3);
    chk("frozen", 8'h31,
        {2'h0, protect_from_bottom, freeze_locked, program_error, block_protect_bits});
    host.frame({16'h0000, 8'hF0}, 1);
    chk("freeze soft", 8'h0F, {4'h0, freeze_locked, block_protect_bits});
    @(negedge ref_clk) hw_reset_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    hw_reset_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("freeze hw", 8'h07, {4'h0, freeze_locked, block_protect_bits});
    $display("test freeze done");
    clk_en = 1'b0;
    host.frame({16'h0000, 8'h75}, 1);
    clk_en = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("clk_en hold", 8'h00, {7'h00, erase_suspended_flag});
    $display("test clock enable done");
    end_sim();
  end
endmodule : flash_config_status_regs_tb
